// ---- pkg/ssdm_pkg.sv ----
/*
 * constants shared by the severely errored frame monitor and its framing
 * byte checker: framing pattern, frame counts, register map and bit layout.
 * assumes one 8-bit register per aligned 32-bit Avalon word.
 */
// Behaviour
// RULE1 - SEF is declared after framing bytes fail in four frames in a row.
// RULE2 - declaring SEF sets bit 1 of the defect status register.
// RULE3 - a declared SEF clears after two frames in a row with clean framing.
// RULE4 - clearing SEF returns bit 1 of the defect status register to zero.
// RULE5 - each SEF change sets interrupt status bit 1 and pulls INT_N low; the code pulls INT_N low only while mask bit 1 is set.
// RULE6 - defect status is read-only, bits 0..7 LOS SEF LOF SD SF K1K2 S1 RDI.
// RULE7 - interrupt status holds LOS SEF LOF B1 B2 REI SD SF, clear on read.
// RULE8 - a read clears interrupt status; INT_N releases when none is set.
package ssdm_pkg;

	// ==================================================================
	// framing pattern
	localparam logic [7:0] FRAMING_A1       = 8'hf6;
	localparam logic [7:0] FRAMING_A2       = 8'h28;
	localparam logic [2:0] A1_BYTES         = 3'h3;
	localparam logic [2:0] FRAMING_BYTES    = 3'h6;

	// ==================================================================
	// declaration and clearance counts, in frames
	localparam logic [2:0] SEF_DECLARE_FRAMES = 3'h4;
	localparam logic [1:0] SEF_CLEAR_FRAMES   = 2'h2;

	// ==================================================================
	// register map: index, byte address is four times the index
	localparam logic [13:0] IDX_DEFECT_STATUS = 14'h1107;
	localparam logic [13:0] IDX_INT_STATUS    = 14'h110b;
	localparam logic [13:0] IDX_INT_MASK      = 14'h110f;
	localparam logic [15:0] ADDR_DEFECT_STATUS = {IDX_DEFECT_STATUS, 2'h0};
	localparam logic [15:0] ADDR_INT_STATUS    = {IDX_INT_STATUS, 2'h0};
	localparam logic [15:0] ADDR_INT_MASK      = {IDX_INT_MASK, 2'h0};

	// ==================================================================
	// field positions and reset values
	localparam int         BIT_SEF            = 1;
	localparam logic [7:0] RST_INT_STATUS     = 8'h00;
	localparam logic [7:0] RST_INT_MASK       = 8'hff;

	typedef enum logic [0:0] {
		ST_IN_FRAME,
		ST_SEF
	} ssdm_state_t;

endpackage

// ---- src/ssdm_frame_check.sv ----
/*
 * checks the three A1 and three A2 bytes at the head of each frame and
 * gives one verdict pulse for each frame whose six framing bytes all arrive.
 * assumes frame_start marks the first A1 byte, on the block's own clock.
 */
`timescale 1ns/10ps
module ssdm_frame_check import ssdm_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// received bytes
	input  wire logic       frame_start,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	// per-frame verdict
	output logic            frame_done,
	output logic            frame_err
);

	logic [2:0] pos_q, pos_d;
	logic       acc_q, acc_d;
	logic       done_q, done_d;
	logic       err_q, err_d;
	logic [7:0] expect_byte;
	logic       miss;

	// ==================================================================
	// byte position and running mismatch
	always_comb begin
		pos_d  = pos_q;
		acc_d  = acc_q;
		done_d = 1'b0;
		err_d  = err_q;
		expect_byte = (pos_q < A1_BYTES) ? FRAMING_A1 : FRAMING_A2;
		miss = byte_data != expect_byte;
		// a new start restarts the check; a cut frame is simply dropped
		if (byte_valid && frame_start) begin
			pos_d = 3'h1;
			acc_d = byte_data != FRAMING_A1;
		end else if (byte_valid && pos_q != 3'h0) begin
			if (pos_q == FRAMING_BYTES - 3'h1) begin
				pos_d  = 3'h0;
				done_d = 1'b1;
				err_d  = acc_q | miss;
			end else begin
				pos_d = pos_q + 3'h1;
				acc_d = acc_q | miss;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pos_q  <= 3'h0;
			acc_q  <= 1'b0;
			done_q <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			pos_q  <= pos_d;
			acc_q  <= acc_d;
			done_q <= done_d;
			err_q  <= err_d;
		end
	end

	assign frame_done = done_q;
	assign frame_err  = err_q;

endmodule

// ---- src/ssdm_sef_monitor.sv ----
/*
 * severely errored frame monitor with its defect status, interrupt
 * status and interrupt mask registers on an Avalon-MM slave.
 * assumes the byte stream and sibling defect/event lines run on CLOCK.
 */
`timescale 1ns/10ps
module ssdm_sef_monitor import ssdm_pkg::*; (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	// received STS-3 byte stream
	input  wire logic        RX_FRAME_START,
	input  wire logic        RX_BYTE_VALID,
	input  wire logic [7:0]  RX_BYTE,
	// sibling monitors: defect levels and one-cycle event pulses
	input  wire logic [7:0]  LINE_DEFECTS,
	input  wire logic [7:0]  LINE_EVENTS,
	// Avalon-MM slave
	input  wire logic [15:0] AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// defect and interrupt
	output logic             SEF_DEFECT,
	output logic             INT_N
);

	logic        frame_done;
	logic        frame_err;
	ssdm_state_t state_q, state_d;
	logic [2:0]  bad_cnt_q, bad_cnt_d;
	logic [1:0]  good_cnt_q, good_cnt_d;
	logic        sef_change;
	logic        sef;
	logic [7:0]  defect_status;

	// ==================================================================
	// framing byte checker
	ssdm_frame_check u_check (
		.clk         (CLOCK),
		.rst         (RESET),
		.frame_start (RX_FRAME_START),
		.byte_valid  (RX_BYTE_VALID),
		.byte_data   (RX_BYTE),
		.frame_done  (frame_done),
		.frame_err   (frame_err)
	);

	// ==================================================================
	// declaration and clearance
	always_comb begin
		state_d    = state_q;
		bad_cnt_d  = bad_cnt_q;
		good_cnt_d = good_cnt_q;
		sef_change = 1'b0;
		if (frame_done) begin
			unique case (state_q)
			ST_IN_FRAME: begin
				good_cnt_d = 2'h0;
				if (!frame_err) begin
					bad_cnt_d = 3'h0;
				end else if (bad_cnt_q == SEF_DECLARE_FRAMES - 3'h1) begin
					state_d    = ST_SEF; // RULE1
					bad_cnt_d  = 3'h0;
					sef_change = 1'b1;
				end else begin
					bad_cnt_d = bad_cnt_q + 3'h1;
				end
			end
			ST_SEF: begin
				bad_cnt_d = 3'h0;
				// one bad frame restarts the clean run
				if (frame_err) begin
					good_cnt_d = 2'h0;
				end else if (good_cnt_q == SEF_CLEAR_FRAMES - 2'h1) begin
					state_d    = ST_IN_FRAME; // RULE3
					good_cnt_d = 2'h0;
					sef_change = 1'b1;
				end else begin
					good_cnt_d = good_cnt_q + 2'h1;
				end
			end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state_q    <= ST_IN_FRAME;
			bad_cnt_q  <= 3'h0;
			good_cnt_q <= 2'h0;
		end else begin
			state_q    <= state_d;
			bad_cnt_q  <= bad_cnt_d;
			good_cnt_q <= good_cnt_d;
		end
	end

	assign sef = state_q == ST_SEF;
	assign SEF_DEFECT = sef;

	// status is composed live; there is nothing software can write here
	always_comb begin
		defect_status = LINE_DEFECTS; // RULE6
		defect_status[BIT_SEF] = sef; // RULE2 RULE4
	end

	// ==================================================================
	// register slave and interrupt
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0]  ist_q, ist_d;
	logic [7:0]  mask_q, mask_d;
	logic [7:0]  events;
	logic        hit_ist;
	logic        lane0;

	assign events  = {LINE_EVENTS[7:2], sef_change, LINE_EVENTS[0]};
	assign hit_ist = AVS_ADDRESS == ADDR_INT_STATUS;
	assign lane0   = AVS_WRITE && AVS_BYTEENABLE[0];
	// one wait state for every access keeps read data registered
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;

	always_comb begin
		ack_d   = (AVS_READ || AVS_WRITE) && !ack_q;
		rdata_d = rdata_q;
		mask_d  = mask_q;
		ist_d   = ist_q;
		if (ack_d && AVS_READ) begin
			unique case (AVS_ADDRESS)
			ADDR_DEFECT_STATUS: rdata_d = {24'h0, defect_status};
			ADDR_INT_STATUS:    rdata_d = {24'h0, ist_q};
			ADDR_INT_MASK:      rdata_d = {24'h0, mask_q};
			default:            rdata_d = 32'h0;
			endcase
		end
		// only the bits the master actually saw are cleared
		if (ack_q && AVS_READ && hit_ist)
			ist_d = ist_q & ~rdata_q[7:0]; // RULE7 RULE8
		if (ack_q && lane0 && hit_ist)
			ist_d = ist_q & ~AVS_WRITEDATA[7:0];
		if (ack_q && lane0 && AVS_ADDRESS == ADDR_INT_MASK)
			mask_d = AVS_WRITEDATA[7:0];
		// a new event wins over a clear in the same cycle
		ist_d = ist_d | events; // RULE5 RULE7
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0;
			ist_q   <= RST_INT_STATUS;
			mask_q  <= RST_INT_MASK;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			ist_q   <= ist_d;
			mask_q  <= mask_d;
		end
	end

	assign AVS_READDATA = rdata_q;
	assign INT_N = !(|(ist_q & mask_q)); // RULE5 RULE8

	// ==================================================================
	// assertions
	property p_declare;
		@(posedge CLOCK) disable iff (RESET)
		(state_q == ST_IN_FRAME && frame_done && frame_err &&
		 bad_cnt_q == 3'h3) |=> sef;
	endproperty
	a_declare: assert property (p_declare) // RULE1
		else $error("sef not declared on fourth bad frame");

	property p_no_early;
		@(posedge CLOCK) disable iff (RESET)
		$rose(sef) |-> $past(bad_cnt_q) == 3'h3 && $past(frame_err);
	endproperty
	a_no_early: assert property (p_no_early) // RULE1
		else $error("sef declared without four bad frames");

	property p_status_read;
		@(posedge CLOCK) disable iff (RESET)
		(AVS_READ && !ack_q && AVS_ADDRESS == ADDR_DEFECT_STATUS) |=>
		AVS_READDATA[BIT_SEF] == $past(sef) &&
		AVS_READDATA[7:2] == $past(LINE_DEFECTS[7:2]) &&
		AVS_READDATA[31:8] == 24'h0;
	endproperty
	a_status_read: assert property (p_status_read) // RULE2 RULE4 RULE6
		else $error("defect status read wrong");

	property p_clear;
		@(posedge CLOCK) disable iff (RESET)
		(sef && frame_done && !frame_err && good_cnt_q == 2'h1) |=> !sef;
	endproperty
	a_clear: assert property (p_clear) // RULE3
		else $error("sef not cleared on second clean frame");

	property p_hold;
		@(posedge CLOCK) disable iff (RESET)
		(sef && frame_done && frame_err) |=> sef ##1 (good_cnt_q == 2'h0);
	endproperty
	a_hold: assert property (p_hold) // RULE3
		else $error("sef left on a bad frame");

	property p_change_irq;
		@(posedge CLOCK) disable iff (RESET)
		$changed(sef) |-> ist_q[BIT_SEF] && (INT_N == !mask_q[BIT_SEF] ||
		 !INT_N);
	endproperty
	a_change_irq: assert property (p_change_irq) // RULE5
		else $error("sef change did not raise interrupt");

	property p_event;
		@(posedge CLOCK) disable iff (RESET)
		(LINE_EVENTS[7] && mask_q[7]) |=> ist_q[7] && !INT_N;
	endproperty
	a_event: assert property (p_event) // RULE7
		else $error("event not latched");

	property p_read_clear;
		@(posedge CLOCK) disable iff (RESET)
		(AVS_READ && ack_q && hit_ist && events == 8'h0) |=>
		(ist_q & $past(rdata_q[7:0])) == 8'h0;
	endproperty
	a_read_clear: assert property (p_read_clear) // RULE8
		else $error("interrupt status not cleared by read");

	property p_release;
		@(posedge CLOCK) disable iff (RESET)
		(ist_q & mask_q) == 8'h0 |-> INT_N;
	endproperty
	a_release: assert property (p_release) // RULE8
		else $error("interrupt held with nothing pending");

	property p_answer;
		@(posedge CLOCK) disable iff (RESET)
		(AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST;
	endproperty
	a_answer: assert property (p_answer)
		else $error("slave did not answer in one wait state");

	c_declare: cover property (@(posedge CLOCK) disable iff (RESET)
		$rose(sef));
	c_clear: cover property (@(posedge CLOCK) disable iff (RESET)
		$fell(sef));
	c_clear_race: cover property (@(posedge CLOCK) disable iff (RESET)
		AVS_READ && ack_q && hit_ist && sef_change);
	c_restart: cover property (@(posedge CLOCK) disable iff (RESET)
		sef && frame_done && frame_err && good_cnt_q == 2'h1);

endmodule

// ---- test/ssdm_line_model.sv ----
/*
 * model of the incoming line stream: sends frames of six framing bytes
 * and four payload bytes, clean or with one framing byte corrupted.
 * assumes the caller enters send just after a rising edge of clk.
 */
`timescale 1ns/10ps
module ssdm_line_model import ssdm_pkg::*; (
	// clock
	input  wire logic  clk,
	// byte stream toward the monitor
	output logic       fs,
	output logic       bv,
	output logic [7:0] bt
);

	// ==================================================================
	// frame source
	initial begin
		fs = 1'b0;
		bv = 1'b0;
		bt = 8'h5a;
	end

	// err below zero is a clean frame, else byte err has one bit flipped
	task automatic send(input int err);
		logic [7:0] b;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			b = (i < 3) ? FRAMING_A1 : (i < 6) ? FRAMING_A2 : 8'h30 + 8'(i);
			if (i == err) b = b ^ 8'h01;
			fs <= (i == 0);
			bv <= 1'b1;
			bt <= b;
		end
		@(posedge clk);
		fs <= 1'b0;
		bv <= 1'b0;
		// idle data never repeats the last byte
		bt <= ~b;
	endtask

	// a frame cut after n bad bytes; the next send restarts at once
	task automatic cut(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			fs <= (i == 0);
			bv <= 1'b1;
			bt <= 8'h00;
		end
	endtask

endmodule

// ---- test/testbench.sv ----
/*
 * self-checking bench for the severely errored frame monitor.
 * assumes the line model drives the byte stream; registers via Avalon-MM.
 */
`timescale 1ns/10ps
module testbench import ssdm_pkg::*;;

	// ==================================================================
	// signals
	logic        clk = 1'b0, rst = 1'b1, fs, bv, wq, sef, int_n;
	logic [7:0]  bt, defs = 8'h00, evs = 8'h00;
	logic [15:0] adr = 16'h0000;
	logic        rd = 1'b0, wr = 1'b0;
	logic [31:0] wd = 32'h0, rdat, rv;
	logic [3:0]  be = 4'h0, be_v = 4'h1;
	int          num_errors = 0, n_compared = 0;

	always #2 clk = ~clk;

	ssdm_sef_monitor dut (.CLOCK(clk), .RESET(rst), .RX_FRAME_START(fs),
		.RX_BYTE_VALID(bv), .RX_BYTE(bt), .LINE_DEFECTS(defs),
		.LINE_EVENTS(evs), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wq), .SEF_DEFECT(sef), .INT_N(int_n));
	ssdm_line_model line (.clk(clk), .fs(fs), .bv(bv), .bt(bt));

	// ==================================================================
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task end_sim;
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// one bus cycle; a read leaves its data in rv
	task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int k;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		be <= be_v;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wq === 1'b0) break;
		end
		if (k == 20) begin
			chk(32'h1, 32'h0, "bus timeout");
			end_sim;
		end
		rv = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task rchk(input logic [15:0] a, input logic [7:0] e, input string m);
		bus(1'b0, a, 8'h00);
		chk(rv, {24'h0, e}, m);
	endtask

	// verdict lands one edge and state change two edges after the last framing byte
	task frame(input int err);
		line.send(err);
		repeat (3) @(posedge clk);
	endtask

	// ==================================================================
	// scenarios
	task t_reset;
		rchk(ADDR_DEFECT_STATUS, 8'h00, "defect reset");
		rchk(ADDR_INT_STATUS, RST_INT_STATUS, "int reset");
		rchk(ADDR_INT_MASK, RST_INT_MASK, "mask reset");
		rchk(16'h0000, 8'h00, "unmapped read");
		chk(int_n, 1'b1, "int idle");
	endtask

	task t_declare;
		for (int i = 0; i < 3; i++) frame(i);
		frame(-1);
		for (int i = 3; i < 6; i++) frame(i);
		chk(sef, 1'b0, "early declare");
		frame(0);
		chk(sef, 1'b1, "no declare");
		chk(int_n, 1'b0, "no int on declare");
		rchk(ADDR_DEFECT_STATUS, 8'h02, "declare status");
		bus(1'b1, ADDR_DEFECT_STATUS, 8'h00);
		rchk(ADDR_DEFECT_STATUS, 8'h02, "status writable");
		rchk(ADDR_INT_STATUS, 8'h02, "declare event");
		chk(int_n, 1'b1, "int after read");
		rchk(ADDR_INT_STATUS, 8'h00, "read not cleared");
	endtask

	task t_clear;
		frame(-1);
		frame(4);
		frame(-1);
		chk(sef, 1'b1, "early clear");
		chk(int_n, 1'b1, "spurious int");
		frame(-1);
		chk(sef, 1'b0, "no clear");
		rchk(ADDR_DEFECT_STATUS, 8'h00, "clear status");
		chk(int_n, 1'b0, "no int on clear");
		bus(1'b1, ADDR_INT_STATUS, 8'h02);
		chk(int_n, 1'b1, "w1c int");
	endtask

	// a cut frame gives no verdict, so three bad frames stay three
	task t_cut;
		for (int i = 0; i < 3; i++) frame(i);
		line.cut(3);
		frame(-1);
		chk(sef, 1'b0, "cut frame judged");
		frame(5);
		chk(sef, 1'b0, "bad run not restarted");
	endtask

	task t_midreset;
		for (int i = 0; i < 4; i++) frame(i);
		chk(sef, 1'b1, "declare before reset");
		be_v = 4'h2;
		bus(1'b1, ADDR_INT_MASK, 8'h00);
		be_v = 4'h1;
		rchk(ADDR_INT_MASK, RST_INT_MASK, "write without lane 0");
		bus(1'b1, 16'h4440, 8'h00);
		rchk(ADDR_INT_MASK, RST_INT_MASK, "unmapped write");
		bus(1'b1, ADDR_INT_MASK, 8'h00);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(sef, 1'b0, "sef after reset");
		chk(int_n, 1'b1, "int after reset");
		rchk(ADDR_INT_STATUS, RST_INT_STATUS, "ist after reset");
		rchk(ADDR_INT_MASK, RST_INT_MASK, "mask after reset");
		rchk(ADDR_DEFECT_STATUS, 8'h00, "defect after reset");
	endtask

	task t_sibling;
		defs <= 8'hff;
		@(posedge clk);
		rchk(ADDR_DEFECT_STATUS, 8'hfd, "sibling defects");
		evs <= 8'hff;
		@(posedge clk);
		evs <= 8'h00;
		@(posedge clk);
		chk(int_n, 1'b0, "sibling int");
		bus(1'b1, ADDR_INT_MASK, 8'h00);
		chk(int_n, 1'b1, "masked int");
		rchk(ADDR_INT_STATUS, 8'hfd, "sibling events");
		rchk(ADDR_INT_STATUS, 8'h00, "events kept");
		bus(1'b1, ADDR_INT_MASK, 8'hff);
	endtask

	// ==================================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_declare;
		t_clear;
		t_cut;
		t_midreset;
		t_sibling;
		end_sim;
	end

endmodule
